// ==== logic/sor_regs.sv ====
`default_nettype none
module sor_regs
	import sor_pkg::*;
#(
	parameter int DW = 16,
	parameter int CLK_HZ = SOR_CLK_HZ
) (
	input wire logic clk,
	input wire logic rst,
	input wire sor_req_t req,
	output logic [7:0] rdata,
	input wire logic nv_load,
	input wire logic [7:0] nv_config_image,
	input wire logic [55:0] nv_offset_image,
	output logic [63:0] nv_save_image,
	input wire logic foc_done,
	input wire logic [55:0] foc_result,
	output logic foc_start,
	input wire logic step_event,
	input wire logic i2c_mode,
	input wire logic autodetect_mode,
	input wire logic sda_pin,
	output logic i2c_disable,
	output logic wdt_timeout,
	output logic gyr_self_test,
	output logic acc_self_test,
	output logic acc_st_amp,
	output logic acc_st_sign,
	input wire logic [3*DW-1:0] acc_raw,
	input wire logic [3*DW-1:0] gyr_raw,
	output logic [3*DW-1:0] acc_out,
	output logic [3*DW-1:0] gyr_out
);
	// ----------------------------------------
	// storage
	// ----------------------------------------
	logic [7:0] self_test_control;
	logic [7:0] interface_nv_config;
	logic [7:0] sensor_offset_comp [0:6];
	logic [15:0] step_count;
	logic [2:0] sda_sync;
	logic sda_level;
	logic [22:0] wdt_cnt;
	logic wr_st;
	logic wr_nv;
	logic wr_off;
	logic [2:0] off_idx;
	logic step_clr;

	localparam int WDT_SHORT_CYC = CLK_HZ / 1000 * SOR_WDT_SHORT_MS;
	localparam int WDT_LONG_CYC = CLK_HZ / 1000 * SOR_WDT_LONG_MS;

	// the watchdog counter is 23 bits wide; a faster clock needs a wider one
	if (DW < 10) begin : g_bad_width
		$error("data width cannot hold a ten-bit offset");
	end
	if (WDT_SHORT_CYC < 1 || WDT_LONG_CYC > 2 ** 23) begin : g_bad_clock
		$error("watchdog period does not fit the counter");
	end

	function automatic logic [9:0] gyr_off(input int a);
		gyr_off = {sensor_offset_comp[6][2*a +: 2], sensor_offset_comp[3+a]};
	endfunction : gyr_off

	assign wr_st = req.wr && req.addr == SOR_ADDR_SELF_TEST;
	assign wr_nv = req.wr && req.addr == SOR_ADDR_NV_CONFIG;
	assign wr_off = req.wr && req.addr >= SOR_ADDR_OFFSET_FIRST && req.addr <= SOR_ADDR_OFFSET_LAST;
	assign off_idx = 3'(req.addr - SOR_ADDR_OFFSET_FIRST);
	assign step_clr = req.wr && req.addr == SOR_ADDR_CMD && req.wdata == SOR_CMD_STEP_CLR;

	// ----------------------------------------
	// self-test
	// ----------------------------------------
	// outcome goes to a status register outside this bank
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			self_test_control <= SOR_SELF_TEST_RESET;
		end else if (wr_st) begin
			self_test_control <= req.wdata & SOR_SELF_TEST_MASK;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			gyr_self_test <= 1'b0;
			acc_self_test <= 1'b0;
			acc_st_amp <= 1'b0;
			acc_st_sign <= 1'b0;
		end else begin
			gyr_self_test <= self_test_control[SOR_ST_GYR_EN];
			acc_self_test <= self_test_control[1:0] == SOR_ST_ACC_ON;
			acc_st_amp <= self_test_control[SOR_ST_ACC_AMP];
			acc_st_sign <= self_test_control[SOR_ST_ACC_SIGN];
		end
	end

	// ----------------------------------------
	// nonvolatile-backed registers
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			interface_nv_config <= 8'h00;
		end else if (nv_load) begin
			interface_nv_config <= nv_config_image & SOR_NV_CONFIG_MASK;
		end else if (wr_nv) begin
			interface_nv_config <= req.wdata & SOR_NV_CONFIG_MASK;
		end
	end

	// calibration result wins over a host write in the same cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 7; i++) sensor_offset_comp[i] <= 8'h00;
		end else if (nv_load) begin
			for (int i = 0; i < 7; i++) sensor_offset_comp[i] <= nv_offset_image[8*i +: 8];
		end else if (foc_done) begin
			for (int i = 0; i < 7; i++) sensor_offset_comp[i] <= foc_result[8*i +: 8];
		end else if (wr_off) begin
			sensor_offset_comp[off_idx] <= req.wdata;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			nv_save_image <= '0;
		end else begin
			nv_save_image <= {sensor_offset_comp[6], sensor_offset_comp[5], sensor_offset_comp[4],
				sensor_offset_comp[3], sensor_offset_comp[2], sensor_offset_comp[1],
				sensor_offset_comp[0], interface_nv_config};
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			foc_start <= 1'b0;
		end else begin
			foc_start <= req.wr && req.addr == SOR_ADDR_CMD && req.wdata == SOR_CMD_START_FOC;
		end
	end

	// ----------------------------------------
	// interface restriction and data-line watchdog
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			i2c_disable <= 1'b0;
		end else begin
			i2c_disable <= autodetect_mode && interface_nv_config[SOR_NV_SPI_ONLY];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			// idle high like the pulled-up line, so no false low follows reset
			sda_sync <= 3'h7;
			sda_level <= 1'b1;
		end else begin
			sda_sync <= {sda_sync[1:0], sda_pin};
			if (sda_sync[2] == sda_sync[1]) sda_level <= sda_sync[2];
		end
	end

	// a data line held low by a stuck transfer trips the timeout
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wdt_cnt <= '0;
			wdt_timeout <= 1'b0;
		end else if (!(i2c_mode && interface_nv_config[SOR_NV_WDT_EN]) || sda_level) begin
			wdt_cnt <= '0;
			wdt_timeout <= 1'b0;
		end else begin
			if (interface_nv_config[SOR_NV_WDT_SEL] ? wdt_cnt >= 23'(WDT_LONG_CYC - 1)
					: wdt_cnt >= 23'(WDT_SHORT_CYC - 1)) begin
				wdt_timeout <= 1'b1;
			end else begin
				wdt_cnt <= wdt_cnt + 23'h1;
			end
		end
	end

	// ----------------------------------------
	// step count
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			step_count <= SOR_STEP_RESET;
		end else if (step_clr) begin
			step_count <= SOR_STEP_RESET;
		end else if (step_event) begin
			step_count <= step_count + 16'h1;
		end
	end

	// ----------------------------------------
	// read path
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata <= 8'h00;
		end else if (req.rd) begin
			if (req.addr == SOR_ADDR_SELF_TEST) rdata <= self_test_control;
			else if (req.addr == SOR_ADDR_NV_CONFIG) rdata <= interface_nv_config;
			else if (req.addr >= SOR_ADDR_OFFSET_FIRST && req.addr <= SOR_ADDR_OFFSET_LAST)
				rdata <= sensor_offset_comp[off_idx];
			else if (req.addr == SOR_ADDR_STEP_LO) rdata <= step_count[7:0];
			else if (req.addr == SOR_ADDR_STEP_HI) rdata <= step_count[15:8];
			else rdata <= 8'h00;
		end
	end

	// ----------------------------------------
	// offset compensation datapath
	// ----------------------------------------
	for (genvar a = 0; a < 3; a++) begin : g_axis
		sor_offset_add #(.W(DW)) u_acc (
			.clk(clk),
			.rst(rst),
			.en(sensor_offset_comp[6][SOR_OFF_ACC_EN]),
			.raw(acc_raw[DW*a +: DW]),
			.offset({{2{sensor_offset_comp[a][7]}}, sensor_offset_comp[a]}),
			.sum(acc_out[DW*a +: DW])
		);
		sor_offset_add #(.W(DW)) u_gyr (
			.clk(clk),
			.rst(rst),
			.en(sensor_offset_comp[6][SOR_OFF_GYR_EN]),
			.raw(gyr_raw[DW*a +: DW]),
			.offset(gyr_off(a)),
			.sum(gyr_out[DW*a +: DW])
		);
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence clr_cmd_s;
		step_clr;
	endsequence

	step_clear_a: assert property (@(posedge clk) disable iff (rst) clr_cmd_s |=> step_count == 16'h0000)
		else $error("step count not cleared");
	step_count_a: assert property (@(posedge clk) disable iff (rst)
		step_event && !step_clr |=> step_count == $past(step_count) + 16'h1)
		else $error("step count did not advance");
	gyro_test_a: assert property (@(posedge clk) disable iff (rst)
		gyr_self_test == $past(self_test_control[SOR_ST_GYR_EN]))
		else $error("gyro self-test not following control");
	acc_test_a: assert property (@(posedge clk) disable iff (rst)
		acc_self_test |-> $past(self_test_control[1:0]) == 2'h1)
		else $error("accel self-test bad field");
	acc_amp_a: assert property (@(posedge clk) disable iff (rst) acc_st_amp == $past(self_test_control[3]))
		else $error("amplitude select wrong");
	acc_sign_a: assert property (@(posedge clk) disable iff (rst) acc_st_sign == $past(self_test_control[2]))
		else $error("sign select wrong");
	nv_load_a: assert property (@(posedge clk) disable iff (rst)
		nv_load |=> interface_nv_config == ($past(nv_config_image) & 8'h07))
		else $error("config not loaded");
	spi_only_a: assert property (@(posedge clk) disable iff (rst)
		i2c_disable |-> $past(autodetect_mode && interface_nv_config[0]))
		else $error("i2c disabled without cause");
	reserved_zero_a: assert property (@(posedge clk) disable iff (rst)
		self_test_control[7:5] == 3'h0 && interface_nv_config[7:3] == 5'h0)
		else $error("reserved bits set");
	foc_store_a: assert property (@(posedge clk) disable iff (rst)
		foc_done && !nv_load |=> sensor_offset_comp[0] == $past(foc_result[7:0]))
		else $error("calibration result not stored");
	wdt_idle_a: assert property (@(posedge clk) disable iff (rst)
		!interface_nv_config[2] |=> !wdt_timeout)
		else $error("watchdog fired while off");
	wdt_count_a: assert property (@(posedge clk) disable iff (rst) i2c_mode && interface_nv_config[SOR_NV_WDT_EN]
		&& !sda_level && wdt_cnt < 23'(WDT_SHORT_CYC - 1) |=> wdt_cnt == $past(wdt_cnt) + 23'h1)
		else $error("watchdog not counting");
	wdt_fire_a: assert property (@(posedge clk) disable iff (rst) $rose(wdt_timeout) |-> wdt_cnt >=
		($past(interface_nv_config[SOR_NV_WDT_SEL]) ? 23'(WDT_LONG_CYC - 1) : 23'(WDT_SHORT_CYC - 1)))
		else $error("watchdog fired early");
	nv_offset_a: assert property (@(posedge clk) disable iff (rst)
		nv_load |=> sensor_offset_comp[6] == $past(nv_offset_image[55:48]))
		else $error("offsets not restored");
	off_write_a: assert property (@(posedge clk) disable iff (rst) wr_off && !nv_load && !foc_done
		|=> sensor_offset_comp[$past(off_idx)] == $past(req.wdata))
		else $error("offset write lost");
endmodule : sor_regs
`default_nettype wire

// ==== logic/sor_pkg.sv ====
`default_nettype none
package sor_pkg;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0] SOR_ADDR_SELF_TEST = 8'h6d;
	localparam logic [7:0] SOR_ADDR_NV_CONFIG = 8'h70;
	localparam logic [7:0] SOR_ADDR_OFFSET_FIRST = 8'h71;
	localparam logic [7:0] SOR_ADDR_OFFSET_LAST = 8'h77;
	localparam logic [7:0] SOR_ADDR_STEP_LO = 8'h78;
	localparam logic [7:0] SOR_ADDR_STEP_HI = 8'h79;
	localparam logic [7:0] SOR_ADDR_CMD = 8'h7e;
	localparam logic [7:0] SOR_SELF_TEST_RESET = 8'h00;
	localparam logic [7:0] SOR_SELF_TEST_MASK = 8'h1f;
	localparam logic [7:0] SOR_NV_CONFIG_MASK = 8'h07;
	localparam logic [15:0] SOR_STEP_RESET = 16'h0000;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int SOR_ST_GYR_EN = 4;
	localparam int SOR_ST_ACC_AMP = 3;
	localparam int SOR_ST_ACC_SIGN = 2;
	localparam logic [1:0] SOR_ST_ACC_ON = 2'h1;
	localparam int SOR_NV_WDT_EN = 2;
	localparam int SOR_NV_WDT_SEL = 1;
	localparam int SOR_NV_SPI_ONLY = 0;
	localparam int SOR_OFF_GYR_EN = 7;
	localparam int SOR_OFF_ACC_EN = 6;
	// ----------------------------------------
	// commands and timing
	// ----------------------------------------
	localparam logic [7:0] SOR_CMD_START_FOC = 8'h03;
	localparam logic [7:0] SOR_CMD_STEP_CLR = 8'hb2;
	localparam int SOR_CLK_HZ = 100_000_000;
	localparam int SOR_WDT_SHORT_MS = 1;
	localparam int SOR_WDT_LONG_MS = 50;
	localparam int SOR_WDT_SHORT_CYC = SOR_CLK_HZ / 1000 * SOR_WDT_SHORT_MS;
	localparam int SOR_WDT_LONG_CYC = SOR_CLK_HZ / 1000 * SOR_WDT_LONG_MS;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sor_req_t;

	typedef struct packed {
		logic [6:0][7:0] byte_val;
	} sor_dummy_t;
endpackage : sor_pkg
`default_nettype wire

// ==== logic/sor_offset_add.sv ====
`default_nettype none
module sor_offset_add
	import sor_pkg::*;
#(
	parameter int W = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic en,
	input wire logic [W-1:0] raw,
	input wire logic [9:0] offset,
	output logic [W-1:0] sum
);
	if (W < 10) begin : g_bad_width
		$error("width too small for offset");
	end
	// offset is sign extended to the data width
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sum <= '0;
		end else if (en) begin
			sum <= raw + {{(W-10){offset[9]}}, offset};
		end else begin
			sum <= raw;
		end
	end
endmodule : sor_offset_add
`default_nettype wire

// ==== verif/sor_host.sv ====
`default_nettype none
module sor_host
	import sor_pkg::*;
#(
	parameter int CLK_HZ = SOR_CLK_HZ
) (
	input wire logic clk,
	input wire logic [7:0] rdata,
	output var sor_req_t req
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [7:0] ACC_CFG_ADDR = 8'h40;
	localparam logic [7:0] ACC_CFG_TEST = 8'h2c;
	localparam int SETTLE_CYC = CLK_HZ / 1000 * 50;
	// ------
	// host side of the register port
	// ------
	initial req = '0;
	// released fields show the inverse, so a design that samples late sees garbage
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		if (a == SOR_ADDR_SELF_TEST)
			d = d & SOR_SELF_TEST_MASK;
		req = '{1'b1, 1'b0, a, d};
		@(posedge clk);
		#1;
		req = '{1'b0, 1'b0, ~a, ~d};
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		#1;
		req = '{1'b0, 1'b1, a, ~a};
		@(posedge clk);
		#1;
		req = '{1'b0, 1'b0, ~a, a};
		d = rdata;
	endtask : rd
	// the accel test only works from the 0x2c configuration, and its output needs time to settle
	task automatic acc_st_begin(input logic [7:0] st);
		wr(ACC_CFG_ADDR, ACC_CFG_TEST);
		wr(SOR_ADDR_SELF_TEST, st);
		repeat (SETTLE_CYC) @(posedge clk);
		#1;
	endtask : acc_st_begin
endmodule : sor_host
`default_nettype wire

// ==== verif/selftest_offset_step_regs_bench.sv ====
`default_nettype none
module selftest_offset_step_regs_bench
	import sor_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	// timeouts are reckoned from a slower nominal clock so the millisecond waits fit the run
	localparam int SCALED_HZ = 100_000;
	logic clk, rst, nv_load, foc_done, step_ev, i2c_mode, auto_mode, sda;
	logic foc_start, i2c_dis, wdt_to, gst, ast, aamp, asign;
	logic [7:0] rdata, nv_cfg, d;
	logic [55:0] nv_off, foc_res;
	logic [63:0] nv_save;
	logic [47:0] acc_raw, gyr_raw, acc_out, gyr_out;
	sor_req_t req;
	int err_total = 0;
	int tests_run = 0;
	int foc_n = 0;
	sor_host #(.CLK_HZ(SCALED_HZ)) host (.clk(clk), .rdata(rdata), .req(req));
	sor_regs #(.DW(16), .CLK_HZ(SCALED_HZ)) DUT (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .nv_load(nv_load),
		.nv_config_image(nv_cfg), .nv_offset_image(nv_off), .nv_save_image(nv_save), .foc_done(foc_done),
		.foc_result(foc_res), .foc_start(foc_start), .step_event(step_ev), .i2c_mode(i2c_mode),
		.autodetect_mode(auto_mode), .sda_pin(sda), .i2c_disable(i2c_dis), .wdt_timeout(wdt_to),
		.gyr_self_test(gst), .acc_self_test(ast), .acc_st_amp(aamp), .acc_st_sign(asign),
		.acc_raw(acc_raw), .gyr_raw(gyr_raw), .acc_out(acc_out), .gyr_out(gyr_out));
	// ------
	// helpers
	// ------
	always @(posedge clk) if (foc_start === 1'b1) foc_n++;
	task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
		tests_run++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		host.rd(a, d);
		chk("rdata", e, d);
	endtask : rchk
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : print_verdict
	// ------
	// scenarios
	// ------
	task automatic t_reset;
		rchk(SOR_ADDR_SELF_TEST, SOR_SELF_TEST_RESET);
		rchk(SOR_ADDR_STEP_LO, 8'h00);
		rchk(SOR_ADDR_STEP_HI, 8'h00);
		$display("reset test done");
	endtask : t_reset
	task automatic t_self;
		logic [7:0] v [6] = '{8'h10, 8'h0d, 8'h09, 8'h04, 8'hff, 8'h00};
		logic [7:0] m;
		foreach (v[i]) begin
			m = v[i] & SOR_SELF_TEST_MASK;
			host.wr(SOR_ADDR_SELF_TEST, v[i]);
			tick(1);
			chk("gyr_self_test", m[SOR_ST_GYR_EN], gst);
			chk("acc_self_test", m[1:0] == SOR_ST_ACC_ON, ast);
			chk("acc_st_amp", m[SOR_ST_ACC_AMP], aamp);
			chk("acc_st_sign", m[SOR_ST_ACC_SIGN], asign);
			rchk(SOR_ADDR_SELF_TEST, m);
		end
		host.acc_st_begin(8'h09);
		chk("acc_self_test", 1'b1, ast);
		rchk(SOR_ADDR_SELF_TEST, 8'h09);
		$display("self-test test done");
	endtask : t_self
	task automatic t_nv;
		nv_cfg = 8'h01;
		nv_off = 56'h01_23_45_67_89_ab_cd;
		nv_load = 1'b1;
		tick(1);
		nv_load = 1'b0;
		auto_mode = 1'b1;
		tick(2);
		chk("i2c_disable", 1'b1, i2c_dis);
		chk("nv_save_image", {nv_off, nv_cfg}, nv_save);
		rchk(SOR_ADDR_NV_CONFIG, 8'h01);
		for (int i = 0; i < 7; i++) rchk(SOR_ADDR_OFFSET_FIRST + 8'(i), nv_off[8*i+:8]);
		host.wr(SOR_ADDR_NV_CONFIG, 8'hfe);
		rchk(SOR_ADDR_NV_CONFIG, 8'h06);
		chk("i2c_disable", 1'b0, i2c_dis);
		host.wr(SOR_ADDR_NV_CONFIG, 8'h01);
		auto_mode = 1'b0;
		tick(2);
		chk("i2c_disable", 1'b0, i2c_dis);
		$display("interface config test done");
	endtask : t_nv
	task automatic t_off;
		logic [55:0] o = 56'hc3_00_00_10_00_00_fe;
		acc_raw = 48'h0010;
		gyr_raw = 48'h0400;
		for (int i = 0; i < 7; i++) host.wr(SOR_ADDR_OFFSET_FIRST + 8'(i), o[8*i+:8]);
		tick(4);
		chk("acc_out", 48'h000e, acc_out);
		chk("gyr_out", 48'h0310, gyr_out);
		// only the accel enable set, so swapped enable bits show up
		host.wr(SOR_ADDR_OFFSET_LAST, 8'h43);
		tick(4);
		chk("acc_out", 48'h000e, acc_out);
		chk("gyr_out", gyr_raw, gyr_out);
		$display("offset test done");
	endtask : t_off
	task automatic t_foc;
		int n0 = foc_n;
		host.wr(SOR_ADDR_CMD, SOR_CMD_START_FOC);
		tick(3);
		chk("foc_start pulses", 1, foc_n - n0);
		foc_res = 56'h80_11_22_33_44_55_66;
		foc_done = 1'b1;
		tick(1);
		foc_done = 1'b0;
		for (int i = 0; i < 7; i++) rchk(SOR_ADDR_OFFSET_FIRST + 8'(i), foc_res[8*i+:8]);
		$display("calibration test done");
	endtask : t_foc
	task automatic t_step;
		repeat (257) begin
			step_ev = 1'b1;
			tick(1);
			step_ev = 1'b0;
			tick(1);
		end
		rchk(SOR_ADDR_STEP_LO, 8'h01);
		rchk(SOR_ADDR_STEP_HI, 8'h01);
		host.wr(SOR_ADDR_STEP_LO, 8'h55);
		rchk(SOR_ADDR_STEP_LO, 8'h01);
		rchk(8'h50, 8'h00);
		host.wr(SOR_ADDR_CMD, SOR_CMD_STEP_CLR);
		rchk(SOR_ADDR_STEP_LO, 8'h00);
		rchk(SOR_ADDR_STEP_HI, 8'h00);
		$display("step count test done");
	endtask : t_step
	task automatic t_wdt;
		host.wr(SOR_ADDR_NV_CONFIG, 8'h04);
		sda = 1'b0;
		tick(150);
		chk("wdt_timeout", 1'b0, wdt_to);
		i2c_mode = 1'b1;
		tick(95);
		chk("wdt_timeout", 1'b0, wdt_to);
		tick(15);
		chk("wdt_timeout", 1'b1, wdt_to);
		sda = 1'b1;
		tick(8);
		chk("wdt_timeout", 1'b0, wdt_to);
		host.wr(SOR_ADDR_NV_CONFIG, 8'h06);
		sda = 1'b0;
		tick(200);
		chk("wdt_timeout", 1'b0, wdt_to);
		tick(4790);
		chk("wdt_timeout", 1'b0, wdt_to);
		tick(30);
		chk("wdt_timeout", 1'b1, wdt_to);
		sda = 1'b1;
		i2c_mode = 1'b0;
		$display("watchdog test done");
	endtask : t_wdt
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		rst = 1'b1;
		nv_load = 1'b0;
		nv_cfg = 8'h00;
		nv_off = '0;
		foc_done = 1'b0;
		foc_res = '0;
		step_ev = 1'b0;
		i2c_mode = 1'b0;
		auto_mode = 1'b0;
		sda = 1'b1;
		acc_raw = '0;
		gyr_raw = '0;
		repeat (10) @(posedge clk);
		#1;
		rst = 1'b0;
		t_reset();
		t_self();
		t_nv();
		t_off();
		t_foc();
		t_step();
		t_wdt();
		print_verdict();
	end
	// whole run is about eleven thousand cycles; this leaves ample margin
	initial begin
		#300000;
		err_total++;
		print_verdict();
	end
endmodule : selftest_offset_step_regs_bench
`default_nettype wire
